/* hdl/ulf_pkg.sv */
// Constants and helpers shared by the interrupt identification and line format block.
package ulf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] OFS_DATA        = 3'h0;
  localparam logic [2:0] OFS_INT_ENABLE  = 3'h1;
  localparam logic [2:0] OFS_INT_IDENT   = 3'h2;
  localparam logic [2:0] OFS_LINE_FORMAT = 3'h3;
  localparam logic [2:0] OFS_DIV_LOW     = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH    = 3'h1;
  localparam logic [2:0] OFS_ENH_FEATURE = 3'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned LF_DLAB     = 7;
  localparam int unsigned LF_BREAK    = 6;
  localparam int unsigned LF_FORCE    = 5;
  localparam int unsigned LF_EVEN     = 4;
  localparam int unsigned LF_PAR_EN   = 3;
  localparam int unsigned LF_STOP     = 2;
  localparam int unsigned EF_ENHANCED = 4;
  localparam logic [7:0]  LF_RESET    = 8'h00;
  localparam logic [7:0]  EF_RESET    = 8'h00;
  localparam logic [7:0]  IE_RESET    = 8'h00;
  localparam logic [15:0] DIV_RESET   = 16'h0000;
  localparam logic [7:0]  READ_ZERO   = 8'h00;

  // ****************************************************************
  // Interrupt sources, highest priority first, and their codes
  // ****************************************************************
  localparam int unsigned NUM_SRC     = 7;
  localparam logic [2:0]  SRC_LINE    = 3'h0;
  localparam logic [2:0]  SRC_RXDATA  = 3'h1;
  localparam logic [2:0]  SRC_TIMEOUT = 3'h2;
  localparam logic [2:0]  SRC_TXEMPTY = 3'h3;
  localparam logic [2:0]  SRC_MODEM   = 3'h4;
  localparam logic [2:0]  SRC_XOFF    = 3'h5;
  localparam logic [2:0]  SRC_FLOW    = 3'h6;
  localparam logic [5:0]  CODE_LINE    = 6'h06;
  localparam logic [5:0]  CODE_RXDATA  = 6'h04;
  localparam logic [5:0]  CODE_TIMEOUT = 6'h0C;
  localparam logic [5:0]  CODE_TXEMPTY = 6'h02;
  localparam logic [5:0]  CODE_MODEM   = 6'h00;
  localparam logic [5:0]  CODE_XOFF    = 6'h10;
  localparam logic [5:0]  CODE_FLOW    = 6'h20;
  localparam logic [5:0]  CODE_NONE    = 6'h01;
  localparam logic [5:0]  CODE_ENH_MASK = 6'h30;
  localparam logic [1:0]  FIFO_ON_BITS  = 2'h3;
  localparam logic [1:0]  FIFO_OFF_BITS = 2'h0;

  // ****************************************************************
  // Character format
  // ****************************************************************
  localparam logic [1:0] WLEN_5 = 2'h0;
  localparam logic [2:0] DATA_BITS_MIN = 3'h5;
  localparam logic [2:0] STOP_HALVES_ONE     = 3'h2;
  localparam logic [2:0] STOP_HALVES_ONEHALF = 3'h3;
  localparam logic [2:0] STOP_HALVES_TWO     = 3'h4;

  typedef enum logic [2:0] {
    ULF_TX_IDLE   = 3'b000,
    ULF_TX_START  = 3'b001,
    ULF_TX_DATA   = 3'b010,
    ULF_TX_PARITY = 3'b011,
    ULF_TX_STOP   = 3'b100
  } ulf_tx_state_t;

  // Parity bit for a character of the programmed length.
  function automatic logic ulf_parity_bit(input logic [7:0] data, input logic [1:0] wlen,
                                          input logic even, input logic forced);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - wlen);
    if (forced) begin
      return ~even;
    end
    return (^(data & mask)) ^ ~even;
  endfunction

endpackage

/* hdl/ulf_int_priority.sv */
// Picks the highest-priority pending interrupt source.
`timescale 1ns/1ps
`default_nettype none
module ulf_int_priority #(
  parameter int unsigned NUM = ulf_pkg::NUM_SRC
) (
  input  wire logic [NUM-1:0] pending,
  output logic                anyPending,
  output logic [2:0]          highest
);

  always_comb begin
    highest = 3'h0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (pending[i]) begin
        highest = 3'(i);
      end
    end
  end

  assign anyPending = |pending;

endmodule // ulf_int_priority
`default_nettype wire

/* hdl/ulf_tx_framer.sv */
// Serialises one held character in the programmed line format.
`timescale 1ns/1ps
`default_nettype none
module ulf_tx_framer (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       halfTick,
  input  wire logic       loadValid,
  input  wire logic [7:0] loadData,
  input  wire logic [1:0] wordLength,
  input  wire logic       parityEnable,
  input  wire logic       evenParity,
  input  wire logic       forceParity,
  input  wire logic       stopLong,
  input  wire logic       breakOn,
  output logic            holdEmpty,
  output logic            serialOut
);

  // ****************************************************************
  // Holding register and shifter
  // ****************************************************************
  ulf_pkg::ulf_tx_state_t state;
  logic [7:0] holdData;
  logic [7:0] shiftData;
  logic       parityBit;
  logic [2:0] bitCount;
  logic [2:0] halfCount;
  logic [2:0] stopHalves;
  logic       lineBit;
  logic [2:0] dataBits;

  assign dataBits = ulf_pkg::DATA_BITS_MIN + {1'b0, wordLength};
  always_comb begin
    if (!stopLong) begin
      stopHalves = ulf_pkg::STOP_HALVES_ONE;
    end else if (wordLength == ulf_pkg::WLEN_5) begin
      stopHalves = ulf_pkg::STOP_HALVES_ONEHALF;
    end else begin
      stopHalves = ulf_pkg::STOP_HALVES_TWO;
    end
  end

  // A write while the holding register is full is dropped.
  always_ff @(posedge clock) begin
    if (srst) begin
      holdEmpty <= 1'b1;
      holdData  <= 8'h00;
    end else if (loadValid && holdEmpty) begin
      holdEmpty <= 1'b0;
      holdData  <= loadData;
    end else if (state == ulf_pkg::ULF_TX_IDLE && !holdEmpty) begin
      holdEmpty <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= ulf_pkg::ULF_TX_IDLE;
      shiftData <= 8'h00;
      parityBit <= 1'b0;
      bitCount  <= 3'h0;
      halfCount <= 3'h0;
    end else begin
      case (state)
        ulf_pkg::ULF_TX_IDLE: begin
          if (!holdEmpty) begin
            state     <= ulf_pkg::ULF_TX_START;
            shiftData <= holdData;
            parityBit <= ulf_pkg::ulf_parity_bit(holdData, wordLength, evenParity,
                                                 forceParity);
            halfCount <= 3'h0;
          end
        end
        default: begin
          if (halfTick) begin
            if (state == ulf_pkg::ULF_TX_STOP ? halfCount + 3'h1 == stopHalves
                                              : halfCount == 3'h1) begin
              halfCount <= 3'h0;
              case (state)
                ulf_pkg::ULF_TX_START: begin
                  state    <= ulf_pkg::ULF_TX_DATA;
                  bitCount <= 3'h0;
                end
                ulf_pkg::ULF_TX_DATA: begin
                  shiftData <= shiftData >> 1;
                  bitCount  <= bitCount + 3'h1;
                  if (bitCount + 3'h1 == dataBits) begin
                    state <= parityEnable ? ulf_pkg::ULF_TX_PARITY
                                          : ulf_pkg::ULF_TX_STOP;
                  end
                end
                ulf_pkg::ULF_TX_PARITY: state <= ulf_pkg::ULF_TX_STOP;
                default:                state <= ulf_pkg::ULF_TX_IDLE;
              endcase
            end else begin
              halfCount <= halfCount + 3'h1;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    case (state)
      ulf_pkg::ULF_TX_START:  lineBit = 1'b0;
      ulf_pkg::ULF_TX_DATA:   lineBit = shiftData[0];
      ulf_pkg::ULF_TX_PARITY: lineBit = parityBit;
      default:                lineBit = 1'b1;
    endcase
  end

  // Break overrides the line but lets the current character run on underneath.
  always_ff @(posedge clock) begin
    if (srst) begin
      serialOut <= 1'b1;
    end else begin
      serialOut <= breakOn ? 1'b0 : lineBit;
    end
  end

endmodule // ulf_tx_framer
`default_nettype wire

/* hdl/ulf_line_control.sv */
// Register file, prioritised interrupt identification and line format control.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Seven priority levels; read returns the source frozen as highest when reported
// - Reported interrupt held until serviced
// - Identification read clears only reported interrupt
// - Line status code sets bits two, one
// - Received data code sets only bit two
// - Receive time-out code sets bits three, two
// - Transmit empty sets bit one; modem none
// - Xoff or special character sets bit four
// - Flow-control change sets only bit five
// - Bits five, four need enhanced enable
// - Xoff bit stays until Xon received
// - Top two bits show FIFOs enabled
// - Bit zero low while interrupt pending
// - Format top bit opens divisor, enhanced access
// - Top bit set hides general registers
// - Break bit holds serial output low
// - Forced parity is constant, inverse of even
// - Unforced parity: clear odd, set even
// - Parity enable appends and checks parity
// - Stop bit works with word length
// - Low bits set transmit and receive length
// - Stop: one, or one and a half/two when set
// - Length codes five through eight bits
module ulf_line_control #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic [ulf_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wrData,
  input  wire logic                       wrStrobe,
  input  wire logic                       rdStrobe,
  output logic      [7:0]                 rdData,
  input  wire logic                       fifoEnabled,
  input  wire logic                       lineStatusEvent,
  input  wire logic                       rxDataEvent,
  input  wire logic                       rxTimeoutEvent,
  input  wire logic                       modemChangeEvent,
  input  wire logic                       xoffDetected,
  input  wire logic                       xonReceived,
  input  wire logic                       flowChangeEvent,
  input  wire logic                       rxCharValid,
  input  wire logic [7:0]                 rxCharData,
  input  wire logic                       rxCharParity,
  output logic                            rxParityError,
  output logic [1:0]                      charLength,
  output logic                            parityEnable,
  output logic                            stopLong,
  output logic                            serialOut
);

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic [7:0]       lineFormat;
  logic [7:0]       enhFeature;
  logic [7:0]       intEnable;
  logic [DIV_W-1:0] divisor;
  logic             dlab;
  logic             enhanced;
  logic             generalWr;
  logic             generalRd;
  logic             altWr;

  assign dlab      = lineFormat[ulf_pkg::LF_DLAB];
  assign enhanced  = enhFeature[ulf_pkg::EF_ENHANCED];
  // The format register stays reachable both ways, else software could never leave.
  assign generalWr = wrStrobe && !dlab;
  assign generalRd = rdStrobe && !dlab;
  assign altWr     = wrStrobe && dlab;

  always_ff @(posedge clock) begin
    if (srst) begin
      lineFormat <= ulf_pkg::LF_RESET;
    end else if (wrStrobe && addr == ulf_pkg::OFS_LINE_FORMAT) begin
      lineFormat <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      divisor <= DIV_W'(ulf_pkg::DIV_RESET);
    end else if (altWr && addr == ulf_pkg::OFS_DIV_LOW) begin
      divisor[7:0] <= wrData;
    end else if (altWr && addr == ulf_pkg::OFS_DIV_HIGH) begin
      divisor[DIV_W-1:8] <= wrData[DIV_W-9:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      enhFeature <= ulf_pkg::EF_RESET;
    end else if (altWr && addr == ulf_pkg::OFS_ENH_FEATURE) begin
      enhFeature <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      intEnable <= ulf_pkg::IE_RESET;
    end else if (generalWr && addr == ulf_pkg::OFS_INT_ENABLE) begin
      intEnable <= wrData;
    end
  end

  // ****************************************************************
  // Interrupt pending flags
  // ****************************************************************
  logic [ulf_pkg::NUM_SRC-1:0] pending;
  logic [ulf_pkg::NUM_SRC-1:0] eligible;
  logic [ulf_pkg::NUM_SRC-1:0] setEvent;
  logic [ulf_pkg::NUM_SRC-1:0] clrEvent;
  logic [ulf_pkg::NUM_SRC-1:0] next_pending;
  logic                        txHoldEmpty;
  logic                        txHoldEmptyLast;
  logic                        identRead;
  logic                        curValid;
  logic [2:0]                  curSrc;
  logic                        anyEligible;
  logic [2:0]                  topSrc;

  assign identRead = generalRd && addr == ulf_pkg::OFS_INT_IDENT;

  always_comb begin
    setEvent = '0;
    setEvent[ulf_pkg::SRC_LINE]    = lineStatusEvent;
    setEvent[ulf_pkg::SRC_RXDATA]  = rxDataEvent;
    setEvent[ulf_pkg::SRC_TIMEOUT] = rxTimeoutEvent;
    setEvent[ulf_pkg::SRC_TXEMPTY] = txHoldEmpty && !txHoldEmptyLast;
    setEvent[ulf_pkg::SRC_MODEM]   = modemChangeEvent;
    setEvent[ulf_pkg::SRC_XOFF]    = xoffDetected && enhanced;
    setEvent[ulf_pkg::SRC_FLOW]    = flowChangeEvent && enhanced;
  end

  always_comb begin
    clrEvent = '0;
    if (identRead && curValid && curSrc != ulf_pkg::SRC_XOFF) begin
      clrEvent[curSrc] = 1'b1;
    end
    clrEvent[ulf_pkg::SRC_XOFF] = xonReceived;
  end

  // An event in the same cycle as its clear survives.
  assign next_pending = (pending & ~clrEvent) | setEvent;

  always_ff @(posedge clock) begin
    if (srst) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      txHoldEmptyLast <= 1'b1;
    end else begin
      txHoldEmptyLast <= txHoldEmpty;
    end
  end

  // Enable bits follow the source numbering; enhanced sources vanish when disabled.
  always_comb begin
    eligible = pending & intEnable[ulf_pkg::NUM_SRC-1:0];
    if (!enhanced) begin
      eligible[ulf_pkg::SRC_XOFF] = 1'b0;
      eligible[ulf_pkg::SRC_FLOW] = 1'b0;
    end
  end

  ulf_int_priority #(
    .NUM (ulf_pkg::NUM_SRC)
  ) u_priority (
    .pending    (eligible),
    .anyPending (anyEligible),
    .highest    (topSrc)
  );

  // ****************************************************************
  // Reported interrupt
  // ****************************************************************
  // The reported source is frozen so a newer, higher event cannot change the
  // code between service routine dispatch and the clearing read.
  always_ff @(posedge clock) begin
    if (srst) begin
      curValid <= 1'b0;
      curSrc   <= 3'h0;
    end else if (!curValid) begin
      curValid <= anyEligible;
      curSrc   <= topSrc;
    end else if ((identRead && curSrc != ulf_pkg::SRC_XOFF) || !eligible[curSrc]) begin
      curValid <= 1'b0;
    end
  end

  logic [5:0] identCode;
  logic [7:0] identByte;

  always_comb begin
    if (!curValid) begin
      identCode = ulf_pkg::CODE_NONE;
    end else begin
      case (curSrc)
        ulf_pkg::SRC_LINE:    identCode = ulf_pkg::CODE_LINE;
        ulf_pkg::SRC_RXDATA:  identCode = ulf_pkg::CODE_RXDATA;
        ulf_pkg::SRC_TIMEOUT: identCode = ulf_pkg::CODE_TIMEOUT;
        ulf_pkg::SRC_TXEMPTY: identCode = ulf_pkg::CODE_TXEMPTY;
        ulf_pkg::SRC_MODEM:   identCode = ulf_pkg::CODE_MODEM;
        ulf_pkg::SRC_XOFF:    identCode = ulf_pkg::CODE_XOFF;
        ulf_pkg::SRC_FLOW:    identCode = ulf_pkg::CODE_FLOW;
        default:              identCode = ulf_pkg::CODE_NONE;
      endcase
    end
    if (!enhanced) begin
      identCode = identCode & ~ulf_pkg::CODE_ENH_MASK;
    end
    identByte = {fifoEnabled ? ulf_pkg::FIFO_ON_BITS : ulf_pkg::FIFO_OFF_BITS,
                 identCode};
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] next_rdData;

  always_comb begin
    next_rdData = ulf_pkg::READ_ZERO;
    if (addr == ulf_pkg::OFS_LINE_FORMAT) begin
      next_rdData = lineFormat;
    end else if (dlab) begin
      case (addr)
        ulf_pkg::OFS_DIV_LOW:     next_rdData = divisor[7:0];
        ulf_pkg::OFS_DIV_HIGH:    next_rdData = 8'(divisor[DIV_W-1:8]);
        ulf_pkg::OFS_ENH_FEATURE: next_rdData = enhFeature;
        default:                  next_rdData = ulf_pkg::READ_ZERO;
      endcase
    end else begin
      case (addr)
        ulf_pkg::OFS_INT_ENABLE:  next_rdData = intEnable;
        ulf_pkg::OFS_INT_IDENT:   next_rdData = identByte;
        default:                  next_rdData = ulf_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdData <= ulf_pkg::READ_ZERO;
    end else if (rdStrobe) begin
      rdData <= next_rdData;
    end else begin
      rdData <= ulf_pkg::READ_ZERO;
    end
  end

  // ****************************************************************
  // Baud half-bit tick
  // ****************************************************************
  // One tick per divisor clocks marks half a bit, which is what 1.5 stop bits need.
  // A zero divisor stops the transmitter.
  logic [DIV_W-1:0] baudCount;
  logic             halfTick;

  always_ff @(posedge clock) begin
    if (srst) begin
      baudCount <= '0;
      halfTick  <= 1'b0;
    end else if (divisor == '0 || baudCount + DIV_W'(1) >= divisor) begin
      baudCount <= '0;
      halfTick  <= divisor != '0;
    end else begin
      baudCount <= baudCount + DIV_W'(1);
      halfTick  <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmitter and receive parity check
  // ****************************************************************
  ulf_tx_framer u_tx (
    .clock        (clock),
    .srst         (srst),
    .halfTick     (halfTick),
    .loadValid    (generalWr && addr == ulf_pkg::OFS_DATA),
    .loadData     (wrData),
    .wordLength   (lineFormat[1:0]),
    .parityEnable (lineFormat[ulf_pkg::LF_PAR_EN]),
    .evenParity   (lineFormat[ulf_pkg::LF_EVEN]),
    .forceParity  (lineFormat[ulf_pkg::LF_FORCE]),
    .stopLong     (lineFormat[ulf_pkg::LF_STOP]),
    .breakOn      (lineFormat[ulf_pkg::LF_BREAK]),
    .holdEmpty    (txHoldEmpty),
    .serialOut    (serialOut)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      rxParityError <= 1'b0;
    end else if (rxCharValid) begin
      rxParityError <= lineFormat[ulf_pkg::LF_PAR_EN] &&
                       rxCharParity != ulf_pkg::ulf_parity_bit(rxCharData,
                           lineFormat[1:0], lineFormat[ulf_pkg::LF_EVEN],
                           lineFormat[ulf_pkg::LF_FORCE]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      charLength   <= ulf_pkg::WLEN_5;
      parityEnable <= 1'b0;
      stopLong     <= 1'b0;
    end else begin
      charLength   <= lineFormat[1:0];
      parityEnable <= lineFormat[ulf_pkg::LF_PAR_EN];
      stopLong     <= lineFormat[ulf_pkg::LF_STOP];
    end
  end

endmodule // ulf_line_control
`default_nettype wire

/* tb/ulf_line_control_chk.sv */
// Concurrent checks on the ports of the line control block.
`timescale 1ns/1ps
`default_nettype none
module ulf_line_control_chk (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic [ulf_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                 wrData,
  input wire logic                       wrStrobe,
  input wire logic                       rdStrobe,
  input wire logic [7:0]                 rdData,
  input wire logic                       fifoEnabled,
  input wire logic                       rxCharValid,
  input wire logic                       rxCharParity,
  input wire logic                       rxParityError,
  input wire logic [1:0]                 charLength,
  input wire logic                       parityEnable,
  input wire logic                       stopLong,
  input wire logic                       serialOut
);
  logic [7:0] lf;
  logic [7:0] ef;
  logic       identRd;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ****************************************************************
  // Shadow copies of the format and enhanced registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      lf <= 8'h00;
      ef <= 8'h00;
    end else if (wrStrobe && addr == 3'h3) begin
      lf <= wrData;
    end else if (wrStrobe && addr == 3'h2 && lf[7]) begin
      ef <= wrData;
    end
  end
  assign identRd = rdStrobe && addr == 3'h2 && !lf[7];
  AST_RD_IDLE: assert property (!rdStrobe |=> rdData == 8'h00) else $error("read data not idle");
  AST_LF_READ: assert property (rdStrobe && addr == 3'h3 |=> rdData == lf)
    else $error("format register read back wrong");
  AST_HIDDEN: assert property (rdStrobe && lf[7] && addr[2] |=> rdData == 8'h00)
    else $error("general register visible");
  AST_FIFO_BITS: assert property (identRd |=> rdData[7:6] == {2{$past(fifoEnabled)}})
    else $error("fifo bits wrong");
  AST_NONE_BIT: assert property (identRd |=> rdData[0] == (rdData[5:0] == 6'h01))
    else $error("status bit wrong");
  AST_ENH_ZERO: assert property (identRd && !ef[4] |=> rdData[5:4] == 2'h0)
    else $error("enhanced bits set while disabled");
  AST_CODES: assert property (identRd |=> rdData[5:0] inside {6'h06, 6'h04, 6'h0C,
    6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("illegal code");
  AST_FORMAT: assert property (wrStrobe && addr == 3'h3 |=> ##1 {charLength,
    parityEnable, stopLong} == $past({lf[1:0], lf[3:2]})) else $error("format outputs wrong");
  AST_BREAK: assert property (lf[6] ##1 lf[6] |-> !serialOut)
    else $error("break not held");
  AST_PAR_OFF: assert property (rxCharValid && !lf[3] |=> !rxParityError)
    else $error("parity error without parity");
  AST_FORCED: assert property (rxCharValid && lf[3] && lf[5]
    |=> rxParityError == ($past(rxCharParity) == $past(lf[4])))
    else $error("forced parity wrong");
  cover property (identRd ##1 rdData[5:0] == 6'h10);
  cover property (identRd ##1 rdData[5:0] == 6'h20);
  cover property (rxCharValid ##1 rxParityError);
endmodule // ulf_line_control_chk
bind ulf_line_control ulf_line_control_chk chk (.clock, .srst, .addr, .wrData, .wrStrobe,
  .rdStrobe, .rdData, .fifoEnabled, .rxCharValid, .rxCharParity, .rxParityError,
  .charLength, .parityEnable, .stopLong, .serialOut);
`default_nettype wire

/* tb/ulf_remote.sv */
// Remote serial device that hands received characters to the block.
`timescale 1ns/1ps
`default_nettype none
module ulf_remote (
  input  wire logic       clock,
  input  wire logic       send,
  input  wire logic [7:0] data,
  input  wire logic [7:0] format,
  input  wire logic       corrupt,
  output logic            rxCharValid,
  output logic [7:0]      rxCharData,
  output logic            rxCharParity
);
  logic par;
  always_comb begin
    par = ~format[4];
    for (int i = 0; i < 5 + int'(format[1:0]); i++) begin
      par ^= data[i];
    end
    if (format[5]) begin
      par = ~format[4];
    end
  end
  // Idle lines toggle so a stale character can never pass for a fresh one.
  always_ff @(posedge clock) begin
    rxCharValid <= send;
    rxCharData <= send ? data : ~rxCharData;
    rxCharParity <= send ? par ^ corrupt : ~rxCharParity;
  end
endmodule // ulf_remote
`default_nettype wire

/* tb/ulf_line_control_tb.sv */
// Self-checking testbench of the line control block.
`timescale 1ns/1ps
`default_nettype none
module ulf_line_control_tb;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00;
  logic       wrStrobe = 1'b0;
  logic       rdStrobe = 1'b0;
  logic       fifoEnabled = 1'b0;
  logic [6:0] ev = 7'h00;
  logic       xon = 1'b0;
  logic       send = 1'b0;
  logic       corrupt = 1'b0;
  logic [7:0] txChar = 8'h00;
  logic [7:0] fmt = 8'h00;
  logic [7:0] rdData, rxCharData, f, v;
  logic [1:0] charLength;
  logic       rxCharValid, rxCharParity, rxParityError, parityEnable, stopLong, serialOut, c;
  int errors = 0;
  int compares = 0;
  int seed = 32'h0000_30f9;
  int pend = 0;
  int ie = 0;
  int enh = 0;
  int cur = 7;
  int codes [8] = '{6, 4, 12, 2, 0, 16, 32, 1};
  always #5 clock = ~clock;
  ulf_line_control uut (.clock(clock), .srst(srst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .fifoEnabled(fifoEnabled),
    .lineStatusEvent(ev[0]), .rxDataEvent(ev[1]), .rxTimeoutEvent(ev[2]),
    .modemChangeEvent(ev[4]), .xoffDetected(ev[5]), .xonReceived(xon),
    .flowChangeEvent(ev[6]), .rxCharValid(rxCharValid), .rxCharData(rxCharData),
    .rxCharParity(rxCharParity), .rxParityError(rxParityError), .charLength(charLength),
    .parityEnable(parityEnable), .stopLong(stopLong), .serialOut(serialOut));
  ulf_remote partner (.clock(clock), .send(send), .data(txChar), .format(fmt),
    .corrupt(corrupt), .rxCharValid(rxCharValid), .rxCharData(rxCharData),
    .rxCharParity(rxCharParity));
  // ****************************************************************
  // Bus tasks and the interrupt model
  // ****************************************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  function automatic int top();
    int i = 0;
    while (i < 7 && (((pend & ie) >> i) & 1) == 0) i++;
    return i;
  endfunction
  // A reported source stays frozen until read, so only an idle model picks anew.
  task pulse(input logic [6:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 7'h00;
    pend |= m & (enh ? 'h7F : 'h1F);
    if (cur == 7) cur = top();
    repeat (2) @(posedge clock);
  endtask
  task rdIdent;
    logic [7:0] e;
    repeat (2) @(posedge clock);
    e = 8'(codes[cur]) | (fifoEnabled ? 8'hC0 : 8'h00);
    rd(3'h2, v);
    chk(v, e);
    if (cur != 5 && cur < 7) pend &= ~(1 << cur);
    if (cur != 5) cur = top();
  endtask
  task finish_test;
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd(3'h2, v);
    chk(v, 8'h01);
    rd(3'h3, v);
    chk(v, 8'h00);
    fifoEnabled <= 1'b1;
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h10);
    rd(3'h2, v);
    chk(v, 8'h10);
    rd(3'h7, v);
    chk(v, 8'h00);
    wr(3'h3, 8'h00);
    enh = 1;
    ie = 'h77;
    wr(3'h1, 8'h77);
    pulse(7'h77);
    repeat (6) rdIdent();
    @(posedge clock);
    xon <= 1'b1;
    @(posedge clock);
    xon <= 1'b0;
    pend &= ~'h20;
    cur = top();
    repeat (2) rdIdent();
    pulse(7'h10);
    pulse(7'h01);
    repeat (3) rdIdent();
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    enh = 0;
    pulse(7'h60);
    rdIdent();
    repeat (8) begin
      f = 8'($random(seed)) & 8'h7F;
      c = 1'($random(seed));
      wr(3'h3, f);
      rd(3'h3, v);
      chk(v, f);
      chk({6'h00, charLength}, {6'h00, f[1:0]});
      chk({6'h00, stopLong, parityEnable}, {6'h00, f[2], f[3]});
      chk({7'h00, serialOut}, {7'h00, !f[6]});
      @(posedge clock);
      fmt <= f;
      corrupt <= c;
      txChar <= 8'($random(seed));
      send <= 1'b1;
      @(posedge clock);
      send <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk({7'h00, rxParityError}, {7'h00, f[3] & c});
    end
    wr(3'h3, 8'h00);
    finish_test;
  end
endmodule // ulf_line_control_tb
`default_nettype wire
